// File: design/cefc_delay.v
// per-pin request filter: polarity, ignore and restart delay on level changes
`timescale 1ns/1ps
`include "cefc_map.vh"
module cefc_delay #(
  parameter DELAY_CYC = 32'd10000000
) (
  // clock and reset
  input wire clock,
  input wire rstn,
  // synchronised pin and config
  input wire pin_sync,
  input wire honour,
  input wire pos_pol,
  // filtered request
  output reg req_on_q
);
  reg [31:0] cnt_q;
  reg raw_last_q;
  wire raw_on;
  // ignored pin always requests on; polarity picks the active level
  assign raw_on = !honour | (pos_pol ? pin_sync : !pin_sync); // RL7 RL8 RL10
  // a change restarts the delay; output follows only after it expires
  always @(posedge clock) begin
    if (!rstn) begin
      cnt_q <= 32'h0000_0000;
      raw_last_q <= 1'b0;
      req_on_q <= 1'b0;
    end else begin
      raw_last_q <= raw_on;
      if (raw_on != raw_last_q) begin
        cnt_q <= DELAY_CYC; // RL12
      end else if (cnt_q != 32'h0000_0000) begin
        cnt_q <= cnt_q - 32'h0000_0001;
        if (cnt_q == 32'h0000_0001) begin
          req_on_q <= raw_last_q; // RL12
        end
      end else begin
        req_on_q <= raw_last_q;
      end
    end
  end
endmodule

// File: design/cefc_top.v
// enable combination, thermal, short-circuit hiccup and overvoltage control with AXI4-Lite regs
// Operation
// RL1: over-temperature at shutdown point powers the output down
// RL2: restart after over-temp only below limit minus hysteresis
// RL3: host sets temp limits, responses and hysteresis over the bus
// RL4: peak current in short-circuit range turns switching outputs off
// RL5: after short-circuit wait long timeout, then normal start with soft start
// RL6: hiccup repeats while fault persists; resume normal once cleared
// RL7: negative polarity: low requests on, open or high requests off
// RL8: positive polarity: open or high requests on, low requests off
// RL9: primary pin config honoured by default; pin must assert to start
// RL10: secondary pin ignored by default; ignored pin always requests on
// RL11: run only while both pins and host operation all request on
// RL12: enable pin change applies 100 ms delay before on or off
// RL13: overvoltage sensed at output power pin shuts output down
// RL14: combined enable re-evaluated every cycle; off starts shutdown at once
`timescale 1ns/1ps
`include "cefc_map.vh"
module cefc_top #(
  parameter RESTART_CYC = `CEFC_RESTART_MS * `CEFC_CYC_PER_MS,
  parameter HICCUP_CYC = `CEFC_HICCUP_MS * `CEFC_CYC_PER_MS,
  parameter SOFT_CYC = `CEFC_SOFT_MS * `CEFC_CYC_PER_MS
) (
  // clock and reset
  input wire clock,
  input wire rstn,
  // enable pins, high means open or pulled high
  input wire enable1_pin,
  input wire enable2_pin,
  // analog comparators and temperature sample
  input wire sc_peak_pin,
  input wire ovp_vout_pin,
  input wire [15:0] temp_code,
  // converter control
  output reg switch_en_q,
  output reg soft_start_q,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  // power states; spare codes fall back to off
  localparam ST_OFF = 3'd0;
  localparam ST_SOFT = 3'd1;
  localparam ST_RUN = 3'd2;
  localparam ST_HICCUP = 3'd3;
  localparam ST_THERM = 3'd4;

  // host settings, each rewritten whole by a bus write
  reg operation_q;
  reg [1:0] pri_cfg_q;
  reg [1:0] sec_cfg_q;
  reg [15:0] ot_limit_q;
  reg [15:0] ot_hys_q;
  reg [15:0] ut_limit_q;
  reg [1:0] response_q;
  // sequencing state and fault bits, sticky except the under-temp flag
  reg [2:0] state_q;
  reg [31:0] tmr_q;
  reg ot_flag_q;
  reg ut_flag_q;
  reg sc_seen_q;
  reg ov_seen_q;
  // two-flop chains for the asynchronous pins
  reg [1:0] en1_s_q;
  reg [1:0] en2_s_q;
  reg [1:0] sc_s_q;
  reg [1:0] ov_s_q;
  // write halves held until both have arrived
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg aw_have_q;
  reg w_have_q;
  // filtered requests and fault decode
  wire req1_on;
  wire req2_on;
  wire enable_all;
  wire sc_now;
  wire ov_now;
  wire signed [15:0] temp_s;
  wire signed [15:0] ot_lim_s;
  wire signed [15:0] ut_lim_s;
  wire signed [16:0] recover_s;
  wire ot_trip;
  wire ot_clear;
  wire ut_trip;
  wire therm_block;
  wire wr_go;

  // two flops on every pin input
  always @(posedge clock) begin
    if (!rstn) begin
      en1_s_q <= 2'b00;
      en2_s_q <= 2'b00;
      sc_s_q <= 2'b00;
      ov_s_q <= 2'b00;
    end else begin
      en1_s_q <= {en1_s_q[0], enable1_pin};
      en2_s_q <= {en2_s_q[0], enable2_pin};
      sc_s_q <= {sc_s_q[0], sc_peak_pin};
      ov_s_q <= {ov_s_q[0], ovp_vout_pin};
    end
  end
  assign sc_now = sc_s_q[1];
  assign ov_now = ov_s_q[1]; // RL13

  // one filter per pin; primary honoured, secondary ignored out of reset
  cefc_delay #(.DELAY_CYC(RESTART_CYC)) u_pri (
    .clock(clock),
    .rstn(rstn),
    .pin_sync(en1_s_q[1]),
    .honour(pri_cfg_q[`CEFC_CFG_HONOUR]), // RL9
    .pos_pol(pri_cfg_q[`CEFC_CFG_POS]),
    .req_on_q(req1_on)
  );
  cefc_delay #(.DELAY_CYC(RESTART_CYC)) u_sec (
    .clock(clock),
    .rstn(rstn),
    .pin_sync(en2_s_q[1]),
    .honour(sec_cfg_q[`CEFC_CFG_HONOUR]), // RL10
    .pos_pol(sec_cfg_q[`CEFC_CFG_POS]),
    .req_on_q(req2_on)
  );
  assign enable_all = req1_on & req2_on & operation_q; // RL11 RL14

  // thermal compare, signed codes; recovery point widened to avoid wrap
  assign temp_s = temp_code;
  assign ot_lim_s = ot_limit_q;
  assign ut_lim_s = ut_limit_q;
  assign recover_s = {ot_lim_s[15], ot_lim_s} - {1'b0, ot_hys_q};
  assign ot_trip = response_q[`CEFC_RSP_OT] & (temp_s >= ot_lim_s); // RL1
  // concatenation drops signedness; cast so readings below zero compare right
  assign ot_clear = ($signed({temp_s[15], temp_s}) < recover_s); // RL2
  assign ut_trip = response_q[`CEFC_RSP_UT] & (temp_s <= ut_lim_s);
  assign therm_block = (ot_flag_q & !ot_clear) | ut_trip;

  // thermal fault flags: over-temp latches until below recovery point
  always @(posedge clock) begin
    if (!rstn) begin
      ot_flag_q <= 1'b0;
      ut_flag_q <= 1'b0;
    end else begin
      if (ot_trip) begin
        ot_flag_q <= 1'b1; // RL1
      end else if (ot_clear) begin
        ot_flag_q <= 1'b0; // RL2
      end
      ut_flag_q <= ut_trip;
    end
  end

  // power state machine; hiccup loops while short persists
  always @(posedge clock) begin
    if (!rstn) begin
      state_q <= ST_OFF;
      tmr_q <= 32'h0000_0000;
      switch_en_q <= 1'b0;
      soft_start_q <= 1'b0;
      sc_seen_q <= 1'b0;
      ov_seen_q <= 1'b0;
    end else begin
      if (tmr_q != 32'h0000_0000) begin
        tmr_q <= tmr_q - 32'h0000_0001;
      end
      if (ov_now) begin
        ov_seen_q <= 1'b1;
      end
      case (state_q)
        ST_OFF: begin
          switch_en_q <= 1'b0;
          soft_start_q <= 1'b0;
          if (enable_all && !therm_block && !ot_trip && !ov_now) begin
            state_q <= ST_SOFT;
            tmr_q <= SOFT_CYC;
            switch_en_q <= 1'b1;
            soft_start_q <= 1'b1;
            ov_seen_q <= 1'b0;
          end
        end
        // off requests win over faults; every off and fault branch drops switching at once
        ST_SOFT, ST_RUN: begin
          if (!enable_all) begin
            state_q <= ST_OFF; // RL14
            switch_en_q <= 1'b0;
            soft_start_q <= 1'b0;
          end else if (ov_now) begin
            state_q <= ST_OFF; // RL13
            switch_en_q <= 1'b0;
            soft_start_q <= 1'b0;
          end else if (ot_trip || ut_trip) begin
            state_q <= ST_THERM; // RL1
            switch_en_q <= 1'b0;
            soft_start_q <= 1'b0;
          end else if (sc_now) begin
            state_q <= ST_HICCUP; // RL4
            tmr_q <= HICCUP_CYC; // RL5
            switch_en_q <= 1'b0;
            soft_start_q <= 1'b0;
            sc_seen_q <= 1'b1;
          end else if (state_q == ST_SOFT && tmr_q == 32'h0000_0001) begin
            state_q <= ST_RUN;
            soft_start_q <= 1'b0;
            sc_seen_q <= 1'b0; // RL6
          end
        end
        ST_HICCUP: begin
          switch_en_q <= 1'b0;
          if (!enable_all) begin
            state_q <= ST_OFF;
          end else if (ov_now || ot_trip || therm_block) begin
            // another fault ends the loop; off restarts only once it clears
            state_q <= ST_OFF; // RL1 RL13
          end else if (tmr_q == 32'h0000_0001) begin
            state_q <= ST_SOFT; // RL5 RL6
            tmr_q <= SOFT_CYC;
            switch_en_q <= 1'b1;
            soft_start_q <= 1'b1;
          end
        end
        ST_THERM: begin
          switch_en_q <= 1'b0;
          soft_start_q <= 1'b0;
          // leave once under-temp clears and, after over-temp, only below the recovery point; off then restarts normally
          if (!therm_block && !ot_trip) begin
            state_q <= ST_OFF; // RL2
          end
        end
        default: begin
          state_q <= ST_OFF;
          switch_en_q <= 1'b0;
          soft_start_q <= 1'b0;
        end
      endcase
    end
  end

  // write channel: address and data taken in either order, response after both
  assign wr_go = aw_have_q & w_have_q & !s_axi_bvalid;
  always @(posedge clock) begin
    if (!rstn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CEFC_RESP_OK;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      operation_q <= `CEFC_RST_OPERATION;
      pri_cfg_q <= `CEFC_RST_PRI_CFG;
      sec_cfg_q <= `CEFC_RST_SEC_CFG;
      ot_limit_q <= `CEFC_RST_OT_LIMIT;
      ot_hys_q <= `CEFC_RST_OT_HYS;
      ut_limit_q <= `CEFC_RST_UT_LIMIT;
      response_q <= `CEFC_RST_RESPONSE;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // byte strobes ignored; all fields sit in the low bytes
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `CEFC_RESP_OK;
        case (awaddr_q)
          `CEFC_OFF_OPERATION: operation_q <= wdata_q[0];
          `CEFC_OFF_PRI_CFG: pri_cfg_q <= wdata_q[1:0];
          `CEFC_OFF_SEC_CFG: sec_cfg_q <= wdata_q[1:0];
          `CEFC_OFF_OT_LIMIT: ot_limit_q <= wdata_q[15:0]; // RL3
          `CEFC_OFF_OT_HYS: ot_hys_q <= wdata_q[15:0]; // RL3
          `CEFC_OFF_UT_LIMIT: ut_limit_q <= wdata_q[15:0]; // RL3
          `CEFC_OFF_RESPONSE: response_q <= wdata_q[1:0]; // RL3
          // read-only offsets accept the write and keep nothing
          `CEFC_OFF_STATUS: s_axi_bresp <= `CEFC_RESP_OK;
          `CEFC_OFF_TEMP: s_axi_bresp <= `CEFC_RESP_OK;
          default: s_axi_bresp <= `CEFC_RESP_SLVERR;
        endcase
      end
    end
  end

  // read channel: one read at a time, data one cycle after address
  always @(posedge clock) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CEFC_RESP_OK;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CEFC_RESP_OK;
        s_axi_rdata <= 32'h0000_0000;
        case (s_axi_araddr)
          `CEFC_OFF_OPERATION: s_axi_rdata <= {31'h0000_0000, operation_q};
          `CEFC_OFF_PRI_CFG: s_axi_rdata <= {30'h0000_0000, pri_cfg_q};
          `CEFC_OFF_SEC_CFG: s_axi_rdata <= {30'h0000_0000, sec_cfg_q};
          `CEFC_OFF_OT_LIMIT: s_axi_rdata <= {16'h0000, ot_limit_q};
          `CEFC_OFF_OT_HYS: s_axi_rdata <= {16'h0000, ot_hys_q};
          `CEFC_OFF_UT_LIMIT: s_axi_rdata <= {16'h0000, ut_limit_q};
          `CEFC_OFF_RESPONSE: s_axi_rdata <= {30'h0000_0000, response_q};
          `CEFC_OFF_STATUS: s_axi_rdata <= {25'h000_0000, soft_start_q,
            (state_q == ST_HICCUP), ov_seen_q, sc_seen_q, ut_flag_q, ot_flag_q,
            switch_en_q};
          `CEFC_OFF_TEMP: s_axi_rdata <= {16'h0000, temp_code};
          // unmapped offsets return zero data with an error
          default: s_axi_rresp <= `CEFC_RESP_SLVERR;
        endcase
      end
    end
  end
endmodule

// File: inc/cefc_map.vh
// register map, field layout, reset values and timing constants of the enable and fault control
`ifndef CEFC_MAP_VH
`define CEFC_MAP_VH
`define CEFC_ADDR_W 8
`define CEFC_OFF_OPERATION 8'h00
`define CEFC_OFF_PRI_CFG 8'h04
`define CEFC_OFF_SEC_CFG 8'h08
`define CEFC_OFF_OT_LIMIT 8'h0C
`define CEFC_OFF_OT_HYS 8'h10
`define CEFC_OFF_UT_LIMIT 8'h14
`define CEFC_OFF_RESPONSE 8'h18
`define CEFC_OFF_STATUS 8'h1C
`define CEFC_OFF_TEMP 8'h20
// pin config fields: bit0 honour pin, bit1 positive polarity
`define CEFC_CFG_HONOUR 0
`define CEFC_CFG_POS 1
// response fields: bit0 shut down on over-temp, bit1 shut down on under-temp
`define CEFC_RSP_OT 0
`define CEFC_RSP_UT 1
`define CEFC_RST_OPERATION 1'b1
`define CEFC_RST_PRI_CFG 2'h1
`define CEFC_RST_SEC_CFG 2'h0
`define CEFC_RST_OT_LIMIT 16'h0078
`define CEFC_RST_OT_HYS 16'h000A
`define CEFC_RST_UT_LIMIT 16'hFFD8
`define CEFC_RST_RESPONSE 2'h3
// status bits
`define CEFC_ST_RUN 0
`define CEFC_ST_OT 1
`define CEFC_ST_UT 2
`define CEFC_ST_SC 3
`define CEFC_ST_OV 4
`define CEFC_ST_HICCUP 5
`define CEFC_ST_SOFT 6
`define CEFC_ST_W 7
// timing
`define CEFC_CLK_MHZ 100
`define CEFC_RESTART_MS 100
`define CEFC_HICCUP_MS 200
`define CEFC_SOFT_MS 10
`define CEFC_CYC_PER_MS (`CEFC_CLK_MHZ * 1000)
`define CEFC_RESP_OK 2'b00
`define CEFC_RESP_SLVERR 2'b10
`endif

// File: verif/cefc_host.sv
// host model reaching the configuration registers over axi4-lite
`timescale 1ns/1ps
module cefc_host (
  // clock
  input wire clock,
  // write address and data
  output reg [7:0] s_axi_awaddr = 8'h00,
  output reg s_axi_awvalid = 1'b0,
  input wire s_axi_awready,
  output reg [31:0] s_axi_wdata = 32'h0000_0000,
  output reg [3:0] s_axi_wstrb = 4'hf,
  output reg s_axi_wvalid = 1'b0,
  input wire s_axi_wready,
  // write response
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  output reg s_axi_bready = 1'b0,
  // read
  output reg [7:0] s_axi_araddr = 8'h00,
  output reg s_axi_arvalid = 1'b0,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  output reg s_axi_rready = 1'b0
);
  // limits and responses set by the host; released lines show inverted data
  task wr(input [7:0] a, input [31:0] d, output [1:0] r);
    begin
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      fork
        begin
          do @(posedge clock); while (!s_axi_awready);
          s_axi_awvalid <= 1'b0;
          s_axi_awaddr <= ~a;
        end
        begin
          do @(posedge clock); while (!s_axi_wready);
          s_axi_wvalid <= 1'b0;
          s_axi_wdata <= ~d;
        end
      join
      do @(posedge clock); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [31:0] d, output [1:0] r);
    begin
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clock); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~a;
      do @(posedge clock); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
endmodule

// File: verif/cefc_props.sv
// concurrent checks on the converter enable, fault and bus behaviour
`timescale 1ns/1ps
module cefc_props #(
  parameter HICCUP_CYC = 40
) (
  // clock and reset
  input wire clock,
  input wire rstn,
  // pins
  input wire enable1_pin,
  input wire sc_peak_pin,
  input wire ovp_vout_pin,
  // converter control
  input wire switch_en_q,
  input wire soft_start_q,
  // bus answers
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // off-time count; hic_q keeps whether a short was seen while switching
  reg hic_q;
  reg [31:0] off_q;
  always @(posedge clock) begin
    if (!rstn || switch_en_q) begin
      hic_q <= rstn && sc_peak_pin;
      off_q <= 32'h0000_0000;
    end else begin
      off_q <= off_q + 32'h0000_0001;
    end
  end
  // pin input has two sync flops plus the output register, so allow slack
  sc_off_a: assert property ($rose(sc_peak_pin) ##1 sc_peak_pin[*3] |-> ##[0:2] !switch_en_q)
    else $error("switching stayed on during a short");
  ov_off_a: assert property (ovp_vout_pin[*6] |-> !switch_en_q)
    else $error("switching stayed on during overvoltage");
  soft_first_a: assert property ($rose(switch_en_q) |-> soft_start_q)
    else $error("start without soft start");
  soft_on_a: assert property (soft_start_q |-> switch_en_q)
    else $error("soft start while switching off");
  hiccup_wait_a: assert property ($rose(switch_en_q) && hic_q |-> off_q >= HICCUP_CYC - 1)
    else $error("restart after short came too soon");
  pin_delay_a: assert property ($changed(enable1_pin) |=> $stable(switch_en_q)[*8])
    else $error("pin change acted without delay");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  cover property ($rose(soft_start_q));
  cover property (hic_q && $rose(switch_en_q));
  cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind cefc_top cefc_props #(.HICCUP_CYC(HICCUP_CYC)) u_props (.*);

// File: verif/cefc_top_tb.sv
// self-checking bench for the converter enable and fault control
`timescale 1ns/1ps
`include "cefc_map.vh"
module cefc_top_tb;
  reg clock = 1'b0;
  reg rstn = 1'b0;
  reg enable1_pin = 1'b1;
  reg enable2_pin = 1'b1;
  reg sc_peak_pin = 1'b0;
  reg ovp_vout_pin = 1'b0;
  reg [15:0] temp_code = 16'h0019;
  wire switch_en_q, soft_start_q, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  wire [7:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  int err_count = 0;
  int tests_run = 0;
  int rises = 0;
  reg [31:0] rd_q;
  reg [1:0] rs_q;
  // rows: primary cfg, secondary cfg, pin1, pin2, expected run
  logic [6:0] rows [8] = '{7'h23, 7'h26, 7'h65, 7'h62, 7'h41, 7'h2A, 7'h3B, 7'h38};
  logic [15:0] dflt [7] = '{16'h0001, 16'h0001, 16'h0000, 16'h0078, 16'h000A, 16'hFFD8,
    16'h0003};
  // short counts keep hiccup and delays quick
  cefc_top #(.RESTART_CYC(20), .HICCUP_CYC(40), .SOFT_CYC(10)) DUT (.*);
  cefc_host host (.*);
  always #5 clock = ~clock;
  always @(posedge soft_start_q) rises++;
  task chk(input [31:0] got, input [31:0] exp, input string nm);
    begin
      tests_run++;
      if (got !== exp) begin
        err_count++;
        $display("[FAIL] %s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task summarize;
    begin
      $display("errors %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask
  // hang guard, well past the planned sequence
  initial begin
    cyc(5000);
    err_count++;
    summarize;
  end
  initial begin
    cyc(3);
    rstn <= 1'b1;
    foreach (dflt[i]) begin
      host.rd(8'(i * 4), rd_q, rs_q);
      chk(rd_q, {16'h0000, dflt[i]}, "default");
    end
    host.rd(8'h40, rd_q, rs_q);
    chk(rs_q, `CEFC_RESP_SLVERR, "unmapped rd");
    host.wr(8'h44, 32'h0000_0000, rs_q);
    chk(rs_q, `CEFC_RESP_SLVERR, "unmapped wr");
    foreach (rows[i]) begin
      host.wr(`CEFC_OFF_PRI_CFG, {30'h0000_0000, rows[i][6:5]}, rs_q);
      host.wr(`CEFC_OFF_SEC_CFG, {30'h0000_0000, rows[i][4:3]}, rs_q);
      enable1_pin <= rows[i][2];
      enable2_pin <= rows[i][1];
      cyc(60);
      chk(switch_en_q, rows[i][0], "run");
    end
    // pin change must wait out the restart delay
    host.wr(`CEFC_OFF_SEC_CFG, 32'h0000_0000, rs_q);
    enable1_pin <= 1'b1;
    cyc(60);
    enable1_pin <= 1'b0;
    cyc(15);
    chk(switch_en_q, 0, "early on");
    cyc(15);
    chk(switch_en_q, 1, "delayed on");
    cyc(20);
    host.wr(`CEFC_OFF_OPERATION, 32'h0000_0000, rs_q);
    cyc(2);
    chk(switch_en_q, 0, "op off");
    host.wr(`CEFC_OFF_OPERATION, 32'h0000_0001, rs_q);
    cyc(30);
    chk(switch_en_q, 1, "op on");
    rises = 0;
    sc_peak_pin <= 1'b1;
    cyc(6);
    chk(switch_en_q, 0, "short off");
    cyc(150);
    chk(rises > 1, 1, "hiccup");
    host.rd(`CEFC_OFF_STATUS, rd_q, rs_q);
    chk(rd_q, (32'h0000_0001 << `CEFC_ST_HICCUP) | (32'h0000_0001 << `CEFC_ST_SC), "sc status");
    sc_peak_pin <= 1'b0;
    cyc(80);
    chk({switch_en_q, soft_start_q}, 2, "resume");
    ovp_vout_pin <= 1'b1;
    cyc(6);
    chk(switch_en_q, 0, "ov off");
    host.rd(`CEFC_OFF_STATUS, rd_q, rs_q);
    chk(rd_q, 32'h0000_0001 << `CEFC_ST_OV, "ov status");
    ovp_vout_pin <= 1'b0;
    cyc(30);
    chk(switch_en_q, 1, "ov gone");
    host.wr(`CEFC_OFF_OT_LIMIT, 32'h0000_0064, rs_q);
    host.wr(`CEFC_OFF_OT_HYS, 32'h0000_000A, rs_q);
    host.rd(`CEFC_OFF_OT_LIMIT, rd_q, rs_q);
    chk(rd_q, 32'h0000_0064, "ot limit");
    temp_code <= 16'h0064;
    cyc(5);
    chk(switch_en_q, 0, "ot trip");
    temp_code <= 16'h005A;
    cyc(30);
    chk(switch_en_q, 0, "ot hys");
    temp_code <= 16'h0059;
    cyc(30);
    chk(switch_en_q, 1, "ot back");
    host.wr(`CEFC_OFF_UT_LIMIT, 32'h0000_0059, rs_q);
    cyc(5);
    chk(switch_en_q, 0, "ut trip");
    host.rd(`CEFC_OFF_STATUS, rd_q, rs_q);
    chk(rd_q, 32'h0000_0001 << `CEFC_ST_UT, "ut status");
    host.rd(`CEFC_OFF_TEMP, rd_q, rs_q);
    chk(rd_q, 32'h0000_0059, "temp rd");
    host.wr(`CEFC_OFF_RESPONSE, 32'h0000_0001, rs_q);
    cyc(30);
    chk(switch_en_q, 1, "ut rsp off");
    rstn <= 1'b0;
    cyc(3);
    chk(switch_en_q, 0, "reset");
    rstn <= 1'b1;
    host.rd(`CEFC_OFF_OT_LIMIT, rd_q, rs_q);
    chk(rd_q, {16'h0000, `CEFC_RST_OT_LIMIT}, "ot limit reset");
    host.rd(`CEFC_OFF_RESPONSE, rd_q, rs_q);
    chk(rd_q, {30'h0000_0000, `CEFC_RST_RESPONSE}, "response reset");
    summarize;
  end
endmodule
